// >>> pkg/touch_spi_pkg.sv
package touch_spi_pkg;

	// ************************************************************
	// link framing
	// ************************************************************
	localparam int          BITS_PER_BYTE  = 8;
	localparam logic [7:0]  IDLE_CODE      = 8'h55;
	localparam logic [7:0]  NULL_CMD       = 8'h00;
	localparam logic [7:0]  CRC_SEED       = 8'h00;
	localparam logic [7:0]  CRC_POLY       = 8'h18;

	// ************************************************************
	// timing
	// ************************************************************
	localparam longint CLK_HZ         = 25000000;
	localparam longint TIMEOUT_MS     = 100;
	localparam longint TIMEOUT_CYCLES = (TIMEOUT_MS * CLK_HZ) / 1000;

	// ************************************************************
	// command codes, whole first byte, and groups, upper two bits of the first byte
	// ************************************************************
	localparam logic [7:0]  CMD_SEND_SETUPS = 8'h01;
	localparam int          SETUP_BYTES     = 42;
	localparam logic [1:0]  GRP_SET         = 2'b10;
	localparam logic [1:0]  GRP_GET         = 2'b11;
	localparam logic [7:0]  CMD_REPORT      = 8'hC1;
	localparam int          REPORT_BYTES    = 2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [2:0]  SYNC_RESET = 3'b111;

	typedef enum {
		ST_CMD,
		ST_RX_DATA,
		ST_RX_CRC,
		ST_TX_DATA,
		ST_TX_CRC
	} phase_t;

endpackage

// >>> core/pin_sync.sv
module pin_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// pin side
	input  wire logic pin_in,
	// synchronised level
	output logic      level_out
);

	typedef struct packed {
		logic [2:0] stages;
		logic       level;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.stages = {st_r.stages[1:0], pin_in};
		// change only once second and third stage agree
		if (st_r.stages[1] == st_r.stages[2]) begin
			st_nxt.level = st_r.stages[2];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= '{stages: touch_spi_pkg::SYNC_RESET, level: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.level;

endmodule

// >>> core/touch_sensor_spi_slave.sv
module touch_sensor_spi_slave #(
	parameter longint TIMEOUT_CYCLES = touch_spi_pkg::TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic       CLK_SYS_IN,
	input  wire logic       RESETN_IN,
	// spi pins
	input  wire logic       SCK_IN,
	input  wire logic       SS_N_IN,
	input  wire logic       MOSI_IN,
	output logic            MISO_OUT,
	output logic            MISO_OE_OUT,
	// configuration and data
	input  wire logic       CRC_EN_IN,
	input  wire logic [7:0] REPORT_DATA_IN,
	input  wire logic [7:0] GET_DATA_IN,
	// accepted command, check error and timeout
	output logic            CMD_VALID_OUT,
	output logic [7:0]      CMD_OUT,
	output logic [7:0]      CMD_DATA_OUT,
	output logic            CRC_ERR_OUT,
	output logic            TIMEOUT_OUT
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		touch_spi_pkg::phase_t phase;
		logic [7:0]            rx_shift;
		logic [7:0]            tx_shift;
		logic [2:0]            bit_cnt;
		logic                  sck_prev;
		logic [5:0]            left;
		logic [7:0]            cmd;
		logic [7:0]            data;
		logic [7:0]            crc;
		logic [7:0]            tx_crc;
		logic [31:0]           idle_cnt;
		logic                  miso;
		logic                  cmd_valid;
		logic                  crc_err;
		logic                  timeout;
		logic [7:0]            cmd_q;
		logic [7:0]            data_q;
	} slave_state_t;

	slave_state_t st_r;
	slave_state_t st_nxt;

	logic sck_s;
	logic ss_n_s;
	logic mosi_s;

	pin_sync u_sync_sck (
		.clk_in   (CLK_SYS_IN),
		.resetn_in(RESETN_IN),
		.pin_in   (SCK_IN),
		.level_out(sck_s)
	);
	pin_sync u_sync_ss (
		.clk_in   (CLK_SYS_IN),
		.resetn_in(RESETN_IN),
		.pin_in   (SS_N_IN),
		.level_out(ss_n_s)
	);
	pin_sync u_sync_mosi (
		.clk_in   (CLK_SYS_IN),
		.resetn_in(RESETN_IN),
		.pin_in   (MOSI_IN),
		.level_out(mosi_s)
	);

	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		logic       fb;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			fb = c[0] ^ d[i];
			// feedback folds in before the shift
			if (fb) begin
				c = c ^ touch_spi_pkg::CRC_POLY;
			end
			c  = {fb, c[7:1]};
		end
		return c;
	endfunction

	logic       rise;
	logic       fall;
	logic [7:0] rx_byte;
	logic [7:0] reply;
	logic       done;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt           = st_r;
		st_nxt.sck_prev  = sck_s;
		st_nxt.cmd_valid = 1'b0;
		st_nxt.crc_err   = 1'b0;
		st_nxt.timeout   = 1'b0;
		rise             = sck_s && !st_r.sck_prev && !ss_n_s;
		fall             = !sck_s && st_r.sck_prev && !ss_n_s;
		rx_byte          = {st_r.rx_shift[6:0], mosi_s};
		done             = rise && (st_r.bit_cnt == 3'd7);
		reply            = touch_spi_pkg::IDLE_CODE;

		if (rise) begin
			st_nxt.rx_shift = rx_byte;
			st_nxt.bit_cnt  = st_r.bit_cnt + 3'd1;
		end
		if (fall) begin
			st_nxt.tx_shift = {st_r.tx_shift[6:0], 1'b0};
			// msb leaves on the first fall
			st_nxt.miso     = st_r.tx_shift[7];
		end
		if (ss_n_s) begin
			st_nxt.bit_cnt = 3'd0;
		end

		if (done || st_r.phase == touch_spi_pkg::ST_CMD) begin
			st_nxt.idle_cnt = 32'd0;
		end else begin
			st_nxt.idle_cnt = st_r.idle_cnt + 32'd1;
		end

		if (done) begin
			unique case (st_r.phase)
				touch_spi_pkg::ST_CMD: begin
					st_nxt.cmd = rx_byte;
					st_nxt.crc = crc_step(touch_spi_pkg::CRC_SEED, rx_byte);
					st_nxt.phase = touch_spi_pkg::ST_CMD;
					if (rx_byte == touch_spi_pkg::CMD_SEND_SETUPS) begin
						st_nxt.left  = 6'(touch_spi_pkg::SETUP_BYTES);
						st_nxt.phase = touch_spi_pkg::ST_RX_DATA;
					end else if (rx_byte[7:6] == touch_spi_pkg::GRP_SET) begin
						st_nxt.left  = 6'd1;
						st_nxt.phase = touch_spi_pkg::ST_RX_DATA;
						reply        = rx_byte;
					end else if (rx_byte == touch_spi_pkg::CMD_REPORT) begin
						st_nxt.left  = 6'(touch_spi_pkg::REPORT_BYTES);
						st_nxt.phase = CRC_EN_IN ? touch_spi_pkg::ST_RX_CRC : touch_spi_pkg::ST_TX_DATA;
						reply        = REPORT_DATA_IN;
					end else if (rx_byte[7:6] == touch_spi_pkg::GRP_GET) begin
						st_nxt.left  = 6'd1;
						st_nxt.phase = CRC_EN_IN ? touch_spi_pkg::ST_RX_CRC : touch_spi_pkg::ST_TX_DATA;
						reply        = GET_DATA_IN;
					end else if (rx_byte != touch_spi_pkg::NULL_CMD) begin
						st_nxt.left = 6'd0;
						if (CRC_EN_IN) begin
							st_nxt.phase = touch_spi_pkg::ST_RX_CRC;
						end else begin
							st_nxt.cmd_valid = 1'b1;
							st_nxt.cmd_q     = rx_byte;
						end
					end
					if (st_nxt.phase == touch_spi_pkg::ST_RX_CRC) begin
						reply = st_nxt.crc;
					end
				end
				touch_spi_pkg::ST_RX_DATA: begin
					st_nxt.data = rx_byte;
					st_nxt.crc  = crc_step(st_r.crc, rx_byte);
					st_nxt.left = st_r.left - 6'd1;
					reply       = rx_byte;
					if (st_r.left == 6'd1) begin
						if (CRC_EN_IN) begin
							st_nxt.phase = touch_spi_pkg::ST_RX_CRC;
							reply        = crc_step(st_r.crc, rx_byte);
						end else begin
							st_nxt.phase     = touch_spi_pkg::ST_CMD;
							st_nxt.cmd_valid = 1'b1;
							st_nxt.cmd_q     = st_r.cmd;
							st_nxt.data_q    = rx_byte;
							reply            = touch_spi_pkg::IDLE_CODE;
						end
					end
				end
				touch_spi_pkg::ST_RX_CRC: begin
					if (rx_byte == st_r.crc && st_r.left == 6'd0) begin
						st_nxt.phase     = touch_spi_pkg::ST_CMD;
						st_nxt.cmd_valid = 1'b1;
						st_nxt.cmd_q     = st_r.cmd;
						st_nxt.data_q    = st_r.data;
					end else if (rx_byte == st_r.crc) begin
						st_nxt.phase  = touch_spi_pkg::ST_TX_DATA;
						st_nxt.tx_crc = touch_spi_pkg::CRC_SEED;
						reply = (st_r.cmd == touch_spi_pkg::CMD_REPORT) ? REPORT_DATA_IN : GET_DATA_IN;
					end else begin
						st_nxt.phase   = touch_spi_pkg::ST_CMD;
						st_nxt.crc_err = 1'b1;
					end
				end
				touch_spi_pkg::ST_TX_DATA: begin
					st_nxt.tx_crc = crc_step(st_r.tx_crc, st_r.data);
					st_nxt.left   = st_r.left - 6'd1;
					reply = (st_r.cmd == touch_spi_pkg::CMD_REPORT) ? REPORT_DATA_IN : GET_DATA_IN;
					if (st_r.left == 6'd1) begin
						if (CRC_EN_IN) begin
							st_nxt.phase = touch_spi_pkg::ST_TX_CRC;
							reply        = crc_step(st_r.tx_crc, st_r.data);
						end else begin
							st_nxt.phase = touch_spi_pkg::ST_CMD;
							reply        = touch_spi_pkg::IDLE_CODE;
						end
					end
				end
				touch_spi_pkg::ST_TX_CRC: begin
					st_nxt.phase = touch_spi_pkg::ST_CMD;
				end
			endcase
			if (st_nxt.phase == touch_spi_pkg::ST_CMD) begin
				reply = touch_spi_pkg::IDLE_CODE;
			end
			st_nxt.data     = (st_r.phase == touch_spi_pkg::ST_TX_DATA) ? st_r.data : st_nxt.data;
			st_nxt.tx_shift = reply;
			st_nxt.miso     = reply[7];
		end
		// track byte being returned for data crc
		if (done && st_nxt.phase == touch_spi_pkg::ST_TX_DATA) begin
			st_nxt.data = reply;
		end

		if (st_r.idle_cnt >= 32'(TIMEOUT_CYCLES - 1) && !done) begin
			st_nxt.phase    = touch_spi_pkg::ST_CMD;
			st_nxt.idle_cnt = 32'd0;
			st_nxt.tx_shift = touch_spi_pkg::IDLE_CODE;
			st_nxt.miso     = touch_spi_pkg::IDLE_CODE[7];
			st_nxt.timeout  = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			st_r <= '{phase: touch_spi_pkg::ST_CMD, tx_shift: touch_spi_pkg::IDLE_CODE,
				miso: touch_spi_pkg::IDLE_CODE[7], sck_prev: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign MISO_OUT      = st_r.miso;
	assign MISO_OE_OUT   = !ss_n_s;
	assign CMD_VALID_OUT = st_r.cmd_valid;
	assign CMD_OUT       = st_r.cmd_q;
	assign CMD_DATA_OUT  = st_r.data_q;
	assign CRC_ERR_OUT   = st_r.crc_err;
	assign TIMEOUT_OUT   = st_r.timeout;

endmodule

// >>> test/touch_spi_chk.sv
module touch_spi_chk #(
	parameter longint TIMEOUT_CYCLES = 2500000
) (
	// clock and reset
	input wire logic       CLK_SYS_IN,
	input wire logic       RESETN_IN,
	// spi pins
	input wire logic       SCK_IN,
	input wire logic       SS_N_IN,
	input wire logic       MISO_OUT,
	input wire logic       MISO_OE_OUT,
	// status
	input wire logic       CRC_EN_IN,
	input wire logic       CMD_VALID_OUT,
	input wire logic [7:0] CMD_OUT,
	input wire logic       CRC_ERR_OUT,
	input wire logic       TIMEOUT_OUT
);
	timeunit 1ns;
	timeprecision 1ns;

	// ********
	// cycles since the link clock last moved
	// ********
	logic [31:0] quiet_r;

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESETN_IN);

	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			quiet_r <= 32'h0;
		end else begin
			quiet_r <= $changed(SCK_IN) ? 32'h0 : quiet_r + 32'h1;
		end
	end

	a_oe_on_select: assert property ($fell(SS_N_IN) |-> ##[1:5] MISO_OE_OUT)
		else $error("miso enable missing after select");
	a_oe_off_idle: assert property (SS_N_IN [*5] |-> !MISO_OE_OUT)
		else $error("miso driven while deselected");
	a_miso_low_quiet: assert property ((!SCK_IN) [*8] |-> $stable(MISO_OUT))
		else $error("miso moved late in clock low phase");
	a_valid_one_cycle: assert property (CMD_VALID_OUT |=> !CMD_VALID_OUT)
		else $error("command pulse too long");
	a_cmd_held: assert property (!CMD_VALID_OUT |-> $stable(CMD_OUT))
		else $error("command changed without pulse");
	a_err_no_accept: assert property (CRC_ERR_OUT |-> !CMD_VALID_OUT)
		else $error("command accepted with bad check byte");
	a_crc_off_quiet: assert property (!CRC_EN_IN |-> !CRC_ERR_OUT)
		else $error("check error with checking off");
	a_pulse_in_frame: assert property ((CMD_VALID_OUT || CRC_ERR_OUT) |-> !SS_N_IN && SCK_IN)
		else $error("byte pulse outside a byte exchange");
	a_timeout_late: assert property ($rose(TIMEOUT_OUT) |-> quiet_r >= TIMEOUT_CYCLES - 8)
		else $error("timeout before the idle span");
endmodule

// >>> test/spi_host_model.sv
module spi_host_model (
	// clock used only to keep pin edges off the sampling edge
	input  wire logic clk_in,
	// spi pins
	output logic      sck_out,
	output logic      ss_n_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 680;

	initial begin
		sck_out  = 1'b1;
		ss_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#300us;
		// align to falling clock, all later steps are whole periods
		@(negedge clk_in);
		ss_n_out = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#HALF sck_out = 1'b0;
			mosi_out = tx[i];
			#HALF sck_out = 1'b1;
			rx[i] = miso_in;
		end
		#HALF ss_n_out = 1'b1;
		mosi_out = ~mosi_out;
	endtask
endmodule

// >>> test/test_touch_sensor_spi_slave.sv
module test_touch_sensor_spi_slave;
	timeunit 1ns;
	timeprecision 1ns;
	localparam longint TO_CYC = 8000;

	logic       clk       = 1'b0;
	logic       resetn    = 1'b0;
	logic       crc_en    = 1'b0;
	logic [7:0] rep       = 8'h00;
	logic [7:0] gdat      = 8'h00;
	wire        sck, ss_n, mosi, miso, miso_oe, cmd_valid, crc_err, tmo;
	wire  [7:0] cmd, cmd_data;
	wire        miso_w    = miso_oe ? miso : 1'bz;
	int         err_total = 0;
	int         compares  = 0;
	int         n_valid   = 0;
	int         n_err     = 0;
	int         n_tmo     = 0;

	spi_host_model host (.clk_in(clk), .sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi), .miso_in(miso_w));

	touch_sensor_spi_slave #(.TIMEOUT_CYCLES(TO_CYC)) DUT (
		.CLK_SYS_IN(clk), .RESETN_IN(resetn), .SCK_IN(sck), .SS_N_IN(ss_n),
		.MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .CRC_EN_IN(crc_en),
		.REPORT_DATA_IN(rep), .GET_DATA_IN(gdat), .CMD_VALID_OUT(cmd_valid),
		.CMD_OUT(cmd), .CMD_DATA_OUT(cmd_data), .CRC_ERR_OUT(crc_err), .TIMEOUT_OUT(tmo)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		n_valid <= n_valid + ((cmd_valid === 1'b1) ? 1 : 0);
		n_err   <= n_err + ((crc_err === 1'b1) ? 1 : 0);
		n_tmo   <= n_tmo + ((tmo === 1'b1) ? 1 : 0);
	end

	// ********
	// reference check byte, reflected
	// ********
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
		end
		return c;
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic xc(input logic [7:0] tx, input logic [7:0] exp);
		logic [7:0] rx;
		host.xfer(tx, rx);
		check("miso", rx, exp);
	endtask

	task automatic summarize();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#4300us;
		err_total++;
		summarize();
	end

	initial begin
		logic [7:0] c;
		logic [7:0] r0;
		logic [7:0] r1;
		void'($urandom(32'hDF0E));
		gdat = 8'($urandom());
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		crc_en <= 1'b1;
		repeat (4) @(posedge clk);
		// set with check byte
		xc(8'h95, 8'h55);
		xc(8'h0C, 8'h95);
		check("early", 8'(n_valid), 8'h00);
		xc(8'h9F, 8'h9F);
		check("valid", 8'(n_valid), 8'h01);
		check("cmd", cmd, 8'h95);
		check("data", cmd_data, 8'h0C);
		// report with check bytes both ways
		r0 = 8'($urandom());
		r1 = 8'($urandom());
		@(posedge clk) rep <= r0;
		xc(8'hC1, 8'h55);
		xc(crc8(8'h00, 8'hC1), crc8(8'h00, 8'hC1));
		@(posedge clk) rep <= r1;
		xc(8'h00, r0);
		xc(8'h00, r1);
		xc(8'h00, crc8(crc8(8'h00, r0), r1));
		check("valid", 8'(n_valid), 8'h01);
		// control with a wrong check byte
		c = 8'h02 + 8'($urandom_range(125));
		xc(c, 8'h55);
		xc(crc8(8'h00, c) ^ 8'h01, crc8(8'h00, c));
		check("crc_err", 8'(n_err), 8'h01);
		check("valid", 8'(n_valid), 8'h01);
		check("cmd", cmd, 8'h95);
		// abandoned set, then fresh command
		@(posedge clk) crc_en <= 1'b0;
		c = 8'h80 + 8'($urandom_range(63));
		xc(c, 8'h55);
		repeat (TO_CYC + 100) @(posedge clk);
		check("timeout", 8'(n_tmo), 8'h01);
		c = 8'h02 + 8'($urandom_range(125));
		xc(c, 8'h55);
		repeat (4) @(posedge clk);
		check("valid", 8'(n_valid), 8'h02);
		check("cmd", cmd, c);
		summarize();
	end
endmodule

bind touch_sensor_spi_slave touch_spi_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
	.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN), .SCK_IN(SCK_IN), .SS_N_IN(SS_N_IN),
	.MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT), .CRC_EN_IN(CRC_EN_IN),
	.CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT), .CRC_ERR_OUT(CRC_ERR_OUT),
	.TIMEOUT_OUT(TIMEOUT_OUT)
);
